// ===== logic/fcw_pkg.sv
// Package with constants and types of the fieldbus communication watchdog
package fcw_pkg;

  // ------------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------------
  localparam logic [15:0] FCW_ADDR_CMD     = 16'hfa00;
  localparam logic [15:0] FCW_ADDR_TIMEOUT = 16'hfa01;
  localparam logic [15:0] FCW_ADDR_STATE   = 16'hfa02;
  localparam logic [15:0] FCW_ADDR_CONFIG  = 16'hfa03;

  // ------------------------------------------------------------------
  // Commands
  // ------------------------------------------------------------------
  localparam logic [15:0] FCW_CMD_ARM   = 16'h5555;
  localparam logic [15:0] FCW_CMD_HALT  = 16'h55aa;
  localparam logic [15:0] FCW_CMD_CLEAR = 16'haaaa;

  // ------------------------------------------------------------------
  // State codes as read back
  // ------------------------------------------------------------------
  localparam logic [15:0] FCW_CODE_NO_TIMEOUT = 16'hffff;
  localparam logic [15:0] FCW_CODE_IDLE       = 16'h0000;
  localparam logic [15:0] FCW_CODE_COUNTING   = 16'h0001;
  localparam logic [15:0] FCW_CODE_TIMED_OUT  = 16'h0002;

  // ------------------------------------------------------------------
  // Exception codes, zero means a normal answer
  // ------------------------------------------------------------------
  localparam logic [7:0] FCW_EXC_NONE      = 8'h00;
  localparam logic [7:0] FCW_EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0] FCW_EXC_ILL_VALUE = 8'h03;

  // ------------------------------------------------------------------
  // Configuration field positions and reset values
  // ------------------------------------------------------------------
  localparam int          FCW_CFG_EXPLICIT_BIT = 0;
  localparam int          FCW_CFG_STATUS_BIT   = 1;
  localparam int          FCW_CFG_DROP_BIT     = 2;
  localparam int          FCW_CFG_AUTO_BIT     = 7;
  localparam logic [15:0] FCW_CFG_MASK         = 16'h0087;
  localparam logic [15:0] FCW_CFG_RESET        = 16'h0004;
  localparam logic [15:0] FCW_TIMEOUT_RESET    = 16'h0000;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int FCW_CLK_HZ     = 40_000_000;
  localparam int FCW_TICK_US    = 1000;
  localparam int FCW_TICK_CYCLES = FCW_CLK_HZ / 1_000_000 * FCW_TICK_US;

  typedef enum logic [1:0] {
    FCW_NO_TIMEOUT,
    FCW_IDLE,
    FCW_COUNTING,
    FCW_TIMED_OUT
  } fcw_state_t;

endpackage

// ===== logic/fcw_watchdog.sv
// Fieldbus communication watchdog: state machine, registers, millisecond tick
`timescale 1ns/1ps
`default_nettype none

module fcw_watchdog
  import fcw_pkg::*;
#(
  parameter int TICK_CYCLES = FCW_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_local,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             rsp_valid,
  output logic             rsp_ack,
  output logic [15:0]      rsp_rdata,
  output logic [7:0]       rsp_exc,
  output logic             timeout_pulse,
  output logic             drop_connections,
  output logic             timed_out
);

  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  if (TICK_CYCLES < 1 || TICK_CYCLES > 1_000_000) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  // ------------------------------------------------------------------
  // Millisecond tick divider
  // ------------------------------------------------------------------
  logic [19:0] div_reg;
  logic [19:0] div_next;
  logic        tick_reg;
  logic        tick_next;

  // Free-running divider, one-cycle enable each millisecond
  // Its phase ignores triggers, so an interval may run up to one tick short
  always_comb begin
    if (div_reg == 20'(TICK_CYCLES - 1)) begin
      div_next  = 20'h00000;
      tick_next = 1'b1;
    end else begin
      div_next  = div_reg + 20'h00001;
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= 20'h00000;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  // ------------------------------------------------------------------
  // Watchdog state and registers
  // ------------------------------------------------------------------
  fcw_state_t  state_reg;
  fcw_state_t  state_next;
  logic [15:0] timeout_reg;
  logic [15:0] timeout_next;
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        rsp_valid_next;
  logic        rsp_ack_next;
  logic [15:0] rsp_rdata_next;
  logic [7:0]  rsp_exc_next;
  logic        pulse_next;

  // ------------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------------
  logic        auto_mode;
  logic        explicit_trig;
  logic        status_trig;
  logic        is_cmd_wr;
  logic        is_arm_wr;
  logic        is_state_rd;
  logic        tmo_locked;
  logic        cfg_locked;
  logic        trigger;
  logic [15:0] state_code;

  // Configuration fields but drop, decoded once for every consumer
  assign auto_mode     = cfg_reg[FCW_CFG_AUTO_BIT];
  assign explicit_trig = cfg_reg[FCW_CFG_EXPLICIT_BIT];
  assign status_trig   = cfg_reg[FCW_CFG_STATUS_BIT];

  // Request strobes, all gated by req_valid so idle bus values never act
  assign is_cmd_wr     = req_valid && req_write && req_addr == FCW_ADDR_CMD;
  assign is_arm_wr     = is_cmd_wr && req_wdata == FCW_CMD_ARM;
  assign is_state_rd   = req_valid && !req_write && req_addr == FCW_ADDR_STATE;

  // A live count keeps its timeout, so no write can shorten a running interval
  assign tmo_locked    = state_reg == FCW_COUNTING || state_reg == FCW_TIMED_OUT;
  // Auto mode keeps the configuration open, since leaving it is the only way to stop
  assign cfg_locked    = !auto_mode && tmo_locked;

  // Read-back code of the state; the enum encoding itself stays free
  always_comb begin
    unique case (state_reg)
      FCW_NO_TIMEOUT: state_code = FCW_CODE_NO_TIMEOUT;
      FCW_IDLE:       state_code = FCW_CODE_IDLE;
      FCW_COUNTING:   state_code = FCW_CODE_COUNTING;
      FCW_TIMED_OUT:  state_code = FCW_CODE_TIMED_OUT;
    endcase
  end

  // ------------------------------------------------------------------
  // Trigger qualification
  // ------------------------------------------------------------------
  // req_local marks a valid request that another service answered
  always_comb begin
    if (explicit_trig) begin
      trigger = is_arm_wr;
    end else if (is_state_rd) begin
      trigger = status_trig;
    end else begin
      trigger = req_valid || req_local;
    end
    if (is_state_rd && status_trig) begin
      trigger = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // State machine, register writes and answers
  // ------------------------------------------------------------------
  // Later assignments win: request handling overrides countdown and trigger
  always_comb begin
    state_next     = state_reg;
    timeout_next   = timeout_reg;
    cfg_next       = cfg_reg;
    count_next     = count_reg;
    rsp_valid_next = req_valid;
    rsp_ack_next   = req_valid;
    rsp_rdata_next = 16'h0000;
    rsp_exc_next   = FCW_EXC_NONE;
    pulse_next     = 1'b0;

    // Countdown on each tick
    if (state_reg == FCW_COUNTING && tick_reg) begin
      if (count_reg <= 16'h0001) begin
        count_next = 16'h0000;
        state_next = FCW_TIMED_OUT;
        pulse_next = 1'b1;
      end else begin
        count_next = count_reg - 16'h0001;
      end
    end

    // Any qualifying trigger restarts the count; auto mode also revives expiry
    if (trigger) begin
      if (state_reg == FCW_COUNTING) begin
        state_next = FCW_COUNTING;
        count_next = timeout_reg;
        pulse_next = 1'b0;
      end else if (state_reg == FCW_TIMED_OUT && auto_mode) begin
        state_next = FCW_COUNTING;
        count_next = timeout_reg;
      end
    end

    if (req_valid && req_write) begin
      unique case (req_addr)
        FCW_ADDR_CMD: begin
          unique case (req_wdata)
            FCW_CMD_ARM: begin
              if (state_reg == FCW_NO_TIMEOUT ||
                  (state_reg == FCW_TIMED_OUT && !auto_mode)) begin
                rsp_exc_next = FCW_EXC_ILL_VALUE;
              end else begin
                state_next = FCW_COUNTING;
                count_next = timeout_reg;
                pulse_next = 1'b0;
              end
            end
            FCW_CMD_HALT: begin
              if (state_reg == FCW_NO_TIMEOUT || auto_mode ||
                  state_reg == FCW_TIMED_OUT) begin
                rsp_exc_next = FCW_EXC_ILL_VALUE;
              end else if (state_reg == FCW_IDLE) begin
                rsp_ack_next = 1'b0;
              end else begin
                state_next = FCW_IDLE;
                pulse_next = 1'b0;
              end
            end
            FCW_CMD_CLEAR: begin
              if (state_reg == FCW_TIMED_OUT && !auto_mode) begin
                state_next = FCW_IDLE;
              end else begin
                rsp_exc_next = FCW_EXC_ILL_VALUE;
              end
            end
            default: begin
              rsp_exc_next = FCW_EXC_ILL_VALUE;
            end
          endcase
        end
        FCW_ADDR_TIMEOUT: begin
          if (tmo_locked) begin
            rsp_exc_next = FCW_EXC_ILL_FUNC;
          end else begin
            timeout_next = req_wdata;
            if (req_wdata == 16'h0000) begin
              state_next = FCW_NO_TIMEOUT;
            end else if (auto_mode) begin
              state_next = FCW_COUNTING;
              count_next = req_wdata;
            end else begin
              state_next = FCW_IDLE;
            end
          end
        end
        FCW_ADDR_CONFIG: begin
          if (cfg_locked) begin
            rsp_exc_next = FCW_EXC_ILL_FUNC;
          end else begin
            cfg_next = req_wdata & FCW_CFG_MASK;
            if (req_wdata[FCW_CFG_AUTO_BIT] && timeout_reg != 16'h0000 &&
                state_reg == FCW_IDLE) begin
              state_next = FCW_COUNTING;
              count_next = timeout_reg;
            end else if (!req_wdata[FCW_CFG_AUTO_BIT] && auto_mode &&
                         timeout_reg != 16'h0000) begin
              state_next = FCW_IDLE;
              pulse_next = 1'b0;
            end
          end
        end
        default: begin
          rsp_exc_next = FCW_EXC_ILL_FUNC;        // state register is read-only
        end
      endcase
    end else if (req_valid) begin
      // Reads write no register but can still trigger; the command port answers like an unknown address
      unique case (req_addr)
        FCW_ADDR_TIMEOUT: rsp_rdata_next = timeout_reg;
        FCW_ADDR_CONFIG:  rsp_rdata_next = cfg_reg;
        FCW_ADDR_STATE:   rsp_rdata_next = state_code;
        default: begin
          rsp_exc_next = FCW_EXC_ILL_FUNC;        // command port not readable
        end
      endcase
    end
  end

  // State, timeout, configuration and live count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= FCW_NO_TIMEOUT;
      timeout_reg <= FCW_TIMEOUT_RESET;
      cfg_reg     <= FCW_CFG_RESET;
      count_reg   <= 16'h0000;
    end else begin
      state_reg   <= state_next;
      timeout_reg <= timeout_next;
      cfg_reg     <= cfg_next;
      count_reg   <= count_next;
    end
  end

  // ------------------------------------------------------------------
  // Answer to the master
  // ------------------------------------------------------------------
  // Fixed one-cycle latency, so the master needs no ready handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_ack   <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_exc   <= FCW_EXC_NONE;
    end else begin
      rsp_valid <= rsp_valid_next;
      rsp_ack   <= rsp_ack_next;
      rsp_rdata <= rsp_rdata_next;
      rsp_exc   <= rsp_exc_next;
    end
  end

  // ------------------------------------------------------------------
  // Expiry outputs
  // ------------------------------------------------------------------
  logic drop_next;
  logic timed_out_next;

  // Drop leaves with the pulse, gated by the bit as it stood before expiry
  always_comb begin
    drop_next      = pulse_next && cfg_reg[FCW_CFG_DROP_BIT];
    timed_out_next = state_next == FCW_TIMED_OUT;
  end

  // Registered so that every expiry output comes straight from a flip-flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_pulse    <= 1'b0;
      drop_connections <= 1'b0;
      timed_out        <= 1'b0;
    end else begin
      timeout_pulse    <= pulse_next;
      drop_connections <= drop_next;
      timed_out        <= timed_out_next;
    end
  end

endmodule

`default_nettype wire

// ===== dv/fcw_watchdog_chk.sv
// Port checker of the communication watchdog
`timescale 1ns/1ps
`default_nettype none
module fcw_watchdog_chk
  import fcw_pkg::*;
#(
  parameter int TICK_CYCLES = FCW_TICK_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic        req_local,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic        rsp_valid,
  input wire logic        rsp_ack,
  input wire logic [15:0] rsp_rdata,
  input wire logic [7:0]  rsp_exc,
  input wire logic        timeout_pulse,
  input wire logic        drop_connections,
  input wire logic        timed_out
);
  // ----------------------------------------------------------------
  // Properties, all in the one clock domain
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_cmd_unreadable: assert property (req_valid && !req_write && req_addr == FCW_ADDR_CMD
    |=> rsp_valid && rsp_exc == FCW_EXC_ILL_FUNC && rsp_rdata == 16'h0000) else $error("command readable");
  a_state_code: assert property (req_valid && !req_write && req_addr == FCW_ADDR_STATE
    |=> rsp_exc == FCW_EXC_NONE && ((rsp_rdata == FCW_CODE_TIMED_OUT) == $past(timed_out)))
    else $error("state code wrong");
  a_tmo_locked: assert property (req_valid && req_write && req_addr == FCW_ADDR_TIMEOUT && timed_out
    |=> rsp_exc == FCW_EXC_ILL_FUNC) else $error("timeout write taken");
  a_pulse_entry: assert property ($rose(timed_out) |-> timeout_pulse) else $error("no pulse on expiry");
  a_pulse_single: assert property (timeout_pulse |-> timed_out ##1 !timeout_pulse)
    else $error("pulse shape wrong");
  a_drop_after: assert property (drop_connections |-> timeout_pulse) else $error("stray drop");
  a_exc_acked: assert property (rsp_valid && rsp_exc != FCW_EXC_NONE |-> rsp_ack)
    else $error("exception not acknowledged");
  a_halt_nack: assert property (rsp_valid && !rsp_ack |-> rsp_exc == 8'h00 && rsp_rdata == 16'h0000)
    else $error("nack carries data");
  a_exc_codes: assert property (rsp_valid |-> rsp_exc inside {8'h00, 8'h01, 8'h03})
    else $error("bad exception code");
endmodule

bind fcw_watchdog fcw_watchdog_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write), .req_local(req_local),
  .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
  .rsp_rdata(rsp_rdata), .rsp_exc(rsp_exc), .timeout_pulse(timeout_pulse),
  .drop_connections(drop_connections), .timed_out(timed_out));
`default_nettype wire

// ===== dv/fcw_master.sv
// Remote fieldbus master model: register requests and foreign triggers
`timescale 1ns/1ps
`default_nettype none
module fcw_master (
  input  wire logic        clk,
  output logic             req_valid,
  output logic             req_write,
  output logic             req_local,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_ack,
  input  wire logic [15:0] rsp_rdata,
  input  wire logic [7:0]  rsp_exc
);
  // Quiet bus at time zero
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_local = 1'b0;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end

  // One register request; released lines show inverted junk so stale values never look valid
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic ok, output logic ak, output logic [15:0] rd, output logic [7:0] ex);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    req_write <= ~w;
    req_addr  <= ~a;
    req_wdata <= ~d;
    // The answer stands for one cycle right after the edge that took the request
    #1;
    ok = rsp_valid;
    ak = rsp_ack;
    rd = rsp_rdata;
    ex = rsp_exc;
  endtask

  // A request to some other service, counted as a trigger only
  task automatic poke();
    @(posedge clk);
    req_local <= 1'b1;
    @(posedge clk);
    req_local <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/fcw_watchdog_test.sv
// Self-checking testbench of the communication watchdog
`timescale 1ns/1ps
`default_nettype none
module fcw_watchdog_test;
  import fcw_pkg::*;
  localparam int TK = 4;
  localparam int LIMIT = 6000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid, req_write, req_local, rsp_valid, rsp_ack, timeout_pulse, drop_connections, timed_out;
  logic [15:0] req_addr, req_wdata, rsp_rdata;
  logic [7:0] rsp_exc;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int pulses = 0;
  int seed, t, p0, n;

  always #12.5 clk = ~clk;

  fcw_master i_master (.clk(clk), .req_valid(req_valid), .req_write(req_write), .req_local(req_local),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_rdata(rsp_rdata), .rsp_exc(rsp_exc));
  fcw_watchdog #(.TICK_CYCLES(TK)) i_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_local(req_local), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .rsp_exc(rsp_exc),
    .timeout_pulse(timeout_pulse), .drop_connections(drop_connections), .timed_out(timed_out));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Request plus checks of answer, exception, data and acknowledge
  task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d,
                    input logic [7:0] e, input logic [15:0] r, input logic k);
    logic ok, ak;
    logic [15:0] rd;
    logic [7:0] ex;
    i_master.xfer(w, a, d, ok, ak, rd, ex);
    chk({15'h0, ok}, 16'h0001, "answer");
    chk({8'h00, ex}, {8'h00, e}, "exception");
    chk(rd, r, "data");
    chk({15'h0, ak}, {15'h0, k}, "ack");
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] e = 8'h00, input logic k = 1'b1);
    op(1'b1, a, d, e, 16'h0000, k);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] r, input logic [7:0] e = 8'h00);
    op(1'b0, a, 16'h0000, e, r, 1'b1);
  endtask

  // Expiry must land inside the tick window; drop stands with the pulse
  task automatic expire(input int lo, input int hi, input logic drop);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (timeout_pulse !== 1'b1 && n < hi + 4);
    chk({15'h0, (n >= lo && n <= hi)}, 16'h0001, "expiry time");
    chk({14'h0, timed_out, drop_connections}, {14'h0, 1'b1, drop}, "drop");
    @(posedge clk);
    #1;
    chk({14'h0, timeout_pulse, drop_connections}, 16'h0000, "pulse end");
  endtask

  // Cycle ceiling and pulse count
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (timeout_pulse === 1'b1) pulses <= pulses + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hb9b67755;
    t = 2 + ($unsigned($random(seed)) % 8);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(FCW_ADDR_TIMEOUT, FCW_TIMEOUT_RESET);
    rd(FCW_ADDR_STATE, FCW_CODE_NO_TIMEOUT);
    rd(FCW_ADDR_CONFIG, FCW_CFG_RESET);
    rd(FCW_ADDR_CMD, 16'h0000, FCW_EXC_ILL_FUNC);
    rd(16'(($unsigned($random(seed))) & 32'h7fff), 16'h0000, FCW_EXC_ILL_FUNC);
    wr(FCW_ADDR_STATE, 16'h0001, FCW_EXC_ILL_FUNC);
    wr(FCW_ADDR_CMD, FCW_CMD_ARM, FCW_EXC_ILL_VALUE);
    wr(FCW_ADDR_CMD, FCW_CMD_HALT, FCW_EXC_ILL_VALUE);
    wr(FCW_ADDR_CMD, FCW_CMD_CLEAR, FCW_EXC_ILL_VALUE);
    wr(FCW_ADDR_TIMEOUT, 16'hffff);
    rd(FCW_ADDR_TIMEOUT, 16'hffff);
    rd(FCW_ADDR_STATE, FCW_CODE_IDLE);
    wr(FCW_ADDR_TIMEOUT, 16'(t));
    wr(FCW_ADDR_CMD, FCW_CMD_HALT, 8'h00, 1'b0);
    wr(FCW_ADDR_CMD, 16'h1234, FCW_EXC_ILL_VALUE);
    wr(FCW_ADDR_CMD, FCW_CMD_ARM);
    rd(FCW_ADDR_STATE, FCW_CODE_COUNTING);
    wr(FCW_ADDR_TIMEOUT, 16'h0005, FCW_EXC_ILL_FUNC);
    wr(FCW_ADDR_CONFIG, 16'h0084, FCW_EXC_ILL_FUNC);
    p0 = pulses;
    repeat (t * 3) i_master.poke();
    chk(16'(pulses - p0), 16'h0000, "kept alive");
    expire((t - 1) * TK - 2, t * TK + 3, 1'b1);
    rd(FCW_ADDR_STATE, FCW_CODE_TIMED_OUT);
    wr(FCW_ADDR_CMD, FCW_CMD_ARM, FCW_EXC_ILL_VALUE);
    wr(FCW_ADDR_CMD, FCW_CMD_HALT, FCW_EXC_ILL_VALUE);
    wr(FCW_ADDR_TIMEOUT, 16'h0003, FCW_EXC_ILL_FUNC);
    wr(FCW_ADDR_CMD, FCW_CMD_CLEAR);
    rd(FCW_ADDR_STATE, FCW_CODE_IDLE);
    // Explicit trigger: foreign requests must not keep it alive
    wr(FCW_ADDR_CONFIG, 16'h0001);
    wr(FCW_ADDR_CMD, FCW_CMD_ARM);
    repeat (t * 3) i_master.poke();
    rd(FCW_ADDR_STATE, FCW_CODE_TIMED_OUT);
    wr(FCW_ADDR_CMD, FCW_CMD_CLEAR);
    // Auto mode with status trigger and no connection drop
    wr(FCW_ADDR_CONFIG, 16'h0082);
    rd(FCW_ADDR_STATE, FCW_CODE_COUNTING);
    wr(FCW_ADDR_CMD, FCW_CMD_HALT, FCW_EXC_ILL_VALUE);
    wr(FCW_ADDR_CMD, FCW_CMD_CLEAR, FCW_EXC_ILL_VALUE);
    wr(FCW_ADDR_CMD, FCW_CMD_ARM);
    p0 = pulses;
    repeat (t * 3) rd(FCW_ADDR_STATE, FCW_CODE_COUNTING);
    chk(16'(pulses - p0), 16'h0000, "status trigger");
    expire((t - 1) * TK - 2, t * TK + 3, 1'b0);
    rd(FCW_ADDR_STATE, FCW_CODE_TIMED_OUT);
    rd(FCW_ADDR_STATE, FCW_CODE_COUNTING);
    wr(FCW_ADDR_CONFIG, 16'h0000);
    rd(FCW_ADDR_STATE, FCW_CODE_IDLE);
    report_and_stop();
  end
endmodule
`default_nettype wire
